// file: mac_dbg_pkg.sv
// constants for the mac dma status and debug register bank
`default_nettype none
package mac_dbg_pkg;
   // ***********************************
   // register byte addresses
   // ***********************************
   localparam logic [31:0] ADDR_PAUSE_CNT = 32'hFFF030C4; // remote_pause_countdown
   localparam logic [31:0] ADDR_LEN_CAP = 32'hFFF030C8; // rx_length_type_capture
   localparam logic [31:0] ADDR_TX_DESC = 32'hFFF030CC; // cur_tx_desc_addr
   localparam logic [31:0] ADDR_TX_BUF = 32'hFFF030D0; // cur_tx_buf_addr
   localparam logic [31:0] ADDR_RX_DESC = 32'hFFF030D4; // cur_rx_desc_addr
   localparam logic [31:0] ADDR_RX_BUF = 32'hFFF030D8; // cur_rx_buf_addr
   localparam logic [31:0] ADDR_RX_SNAP = 32'hFFF03200; // rx_state_snapshot
   localparam logic [31:0] ADDR_TX_SNAP = 32'hFFF03204; // tx_state_snapshot
   localparam logic [31:0] ADDR_SNAP0 = 32'hFFF03208; // state_snapshot_zero
   localparam logic [31:0] ADDR_SNAP1 = 32'hFFF0320C; // state_snapshot_one
   localparam logic [31:0] ADDR_DBG_CFG = 32'hFFF03210; // debug_observe_config
   localparam logic [31:0] ADDR_IRQ_STAT = 32'hFFF03280; // irq status, read only
   localparam logic [31:0] ADDR_IRQ_CLR = 32'hFFF03284; // irq clear, write only
   localparam logic [31:0] ADDR_IRQ_EN = 32'hFFF03288; // irq enable
   // ***********************************
   // reset values
   // ***********************************
   localparam logic [31:0] RST_RX_SNAP = 32'h00811101;
   localparam logic [31:0] RST_TX_SNAP = 32'h01011101;
   localparam logic [31:0] RST_SNAP0 = 32'h00010101;
   localparam logic [31:0] RST_SNAP1 = 32'h11000100;
   localparam logic [5:0] RST_GROUP_SEL = 6'h3F;
   localparam logic [15:0] RST_PAUSE_CNT = 16'h0000;
   localparam logic [15:0] RST_LEN_FIELD = 16'h0000;
   localparam logic [1:0] RST_IRQ = 2'h0;
   // ***********************************
   // field positions
   // ***********************************
   localparam int GROUP_SEL_LSB = 0; // debug group select [5:0]
   localparam int FLAG_LSB = 6; // flag outputs [7:6]
   localparam int FUNC_EN_LSB = 22; // function enables [23:22]
   localparam int IRQ_LEN_BIT = 0; // length/type received
   localparam int IRQ_PAUSE_BIT = 1; // remote pause expired
   localparam int IRQ_WIDTH = 2;
   // ***********************************
   // debug group codes
   // ***********************************
   localparam logic [5:0] GROUP_TX_DMA = 6'h01;
   localparam logic [5:0] GROUP_RX_DMA = 6'h02;
endpackage : mac_dbg_pkg
`default_nettype wire

// file: mac_dma_status_debug_regs.sv
// mac dma status, state snapshot and debug configuration registers
//
// Behaviour
// [R01] pause sent loads countdown, shown in [15:0]
// [R02] every frame length/type captured into [15:0]
// [R03] length/type capture register is write-one-to-clear
// [R04] enabled length event sets status, raises interrupt
// [R05] current tx descriptor address, read only
// [R06] current tx buffer address, read only
// [R07] current rx descriptor address, read only
// [R08] current rx buffer address, read only
// [R09] rx snapshot field layout, documented reset value
// [R10] tx snapshot field layout, documented reset value
// [R11] snapshot zero field layout and reset value
// [R12] snapshot one field layout and reset value
// [R13] snapshots read only, writes ignored
// [R14] six-bit group select, resets all ones
// [R15] config bits [7:6] drive two flags
// [R16] config bits [23:22] drive function enables
// [R17] group one shows flag, tx buffer, tx dma
// [R18] reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
module mac_dma_status_debug_regs (
   input wire logic sys_clk, // 10 MHz system clock
   input wire logic rst, // synchronous, active high
   input wire logic clkEn, // low freezes all state
   // register port
   input wire logic [31:0] regAddr, // byte address
   input wire logic [31:0] regWrData, // write data
   input wire logic regWrStrobe, // one-cycle write
   input wire logic regRdStrobe, // one-cycle read
   output logic [31:0] regRdData, // valid the cycle after a read
   // pause transmit side
   input wire logic pauseTxDone, // pause frame fully sent
   input wire logic [15:0] pauseOperand, // operand of that frame
   input wire logic pauseSlotTick, // one pulse per slot time
   // receive length/type
   input wire logic lenTypeValid, // field of a frame received
   input wire logic [15:0] lenTypeValue, // the field itself
   // dma current addresses
   input wire logic [31:0] txDescAddr,
   input wire logic [31:0] txBufAddr,
   input wire logic [31:0] rxDescAddr,
   input wire logic [31:0] rxBufAddr,
   // live state machine values
   input wire logic [8:0] rxDmaState,
   input wire logic [5:0] rxBufState,
   input wire logic [3:0] rxFetchState,
   input wire logic [3:0] rxCloseState,
   input wire logic [7:0] rxFifoState,
   input wire logic [7:0] txDmaState,
   input wire logic [6:0] txBufState,
   input wire logic [3:0] txFetchState,
   input wire logic [3:0] txCloseState,
   input wire logic [4:0] txFifoState,
   input wire logic [9:0] txMacState,
   input wire logic [5:0] txDeferState,
   input wire logic [7:0] mgmtIfState,
   input wire logic [2:0] arbiterState,
   input wire logic [3:0] pauseTxState,
   input wire logic [5:0] busMasterState,
   // debug and interrupt outputs
   output logic [15:0] debugObserve, // selected signal group
   output logic [1:0] debugFlags, // logic analyzer triggers
   output logic [1:0] funcEnable, // bit 0 enables collision generator
   output logic irq // level, enabled status set
);
   import mac_dbg_pkg::*;

   // ***********************************
   // helpers
   // ***********************************

   // write-one-to-clear, an event arriving in the same cycle wins
   function automatic logic [15:0] w1c16(input logic [15:0] cur, input logic [15:0] clr);
      w1c16 = cur & ~clr;
   endfunction : w1c16

   // write hit for one register address
   function automatic logic wrHit(input logic [31:0] a, input logic [31:0] target, input logic s);
      wrHit = s && (a == target);
   endfunction : wrHit

   // ***********************************
   // state
   // ***********************************
   logic [15:0] pauseCount; // remote pause down-counter
   logic [15:0] lenTypeField; // last captured length/type
   logic [31:0] rxSnap; // registered snapshots
   logic [31:0] txSnap;
   logic [31:0] snapZero;
   logic [31:0] snapOne;
   logic [5:0] groupSel; // debug group select
   logic [IRQ_WIDTH-1:0] irqStatus; // sticky events
   logic [IRQ_WIDTH-1:0] irqEnable; // interrupt gating
   logic [31:0] next_regRdData; // read mux output
   logic pauseExpire; // countdown reaching zero
   logic lenWr; // write to capture register
   logic cfgWr; // write to debug config
   logic clrWr; // write to irq clear
   logic enWr; // write to irq enable

   assign lenWr = wrHit(regAddr, ADDR_LEN_CAP, regWrStrobe);
   assign cfgWr = wrHit(regAddr, ADDR_DBG_CFG, regWrStrobe);
   assign clrWr = wrHit(regAddr, ADDR_IRQ_CLR, regWrStrobe);
   assign enWr = wrHit(regAddr, ADDR_IRQ_EN, regWrStrobe);

   // a tick that takes the count from one to zero ends the pause
   assign pauseExpire = pauseSlotTick && !pauseTxDone && (pauseCount == 16'h0001);

   // ***********************************
   // remote pause countdown
   // ***********************************

   // a new pause frame reloads even mid-count, so load beats the tick
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pauseCount <= RST_PAUSE_CNT;
      end else if (clkEn) begin
         if (pauseTxDone) begin
            pauseCount <= pauseOperand; // R01
         end else if (pauseSlotTick && (pauseCount != 16'h0000)) begin
            pauseCount <= pauseCount - 16'h0001; // R01
         end
      end
   end

   // ***********************************
   // length/type capture
   // ***********************************

   // capture wins over a clear in the same cycle, no frame lost
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lenTypeField <= RST_LEN_FIELD;
      end else if (clkEn) begin
         if (lenTypeValid) begin
            lenTypeField <= lenTypeValue; // R02
         end else if (lenWr) begin
            lenTypeField <= w1c16(lenTypeField, regWrData[15:0]); // R03
         end
      end
   end

   // ***********************************
   // interrupt status and enable
   // ***********************************

   // enable register, plain read/write
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqEnable <= RST_IRQ;
      end else if (clkEn && enWr) begin
         irqEnable <= regWrData[IRQ_WIDTH-1:0];
      end
   end

   // sticky status; length event only counts while enabled
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irqStatus <= RST_IRQ;
      end else if (clkEn) begin
         // clear first, then the sets override
         if (clrWr) begin
            irqStatus <= irqStatus & ~regWrData[IRQ_WIDTH-1:0];
         end
         if (lenTypeValid && irqEnable[IRQ_LEN_BIT]) begin
            irqStatus[IRQ_LEN_BIT] <= 1'b1; // R04
         end
         if (pauseExpire) begin
            irqStatus[IRQ_PAUSE_BIT] <= 1'b1;
         end
      end
   end

   // level interrupt straight from flops
   assign irq = |(irqStatus & irqEnable); // R04

   // ***********************************
   // state snapshots
   // ***********************************

   // sampled every enabled cycle; a read sees state one cycle old
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rxSnap <= RST_RX_SNAP;
         txSnap <= RST_TX_SNAP;
         snapZero <= RST_SNAP0;
         snapOne <= RST_SNAP1;
      end else if (clkEn) begin
         // bit 22 reserved
         rxSnap <= {rxDmaState, 1'b0, rxBufState, rxFetchState, rxCloseState, rxFifoState}; // R09
         // only six of the seven tx buffer bits fit the field
         txSnap <= {txDmaState, 2'b00, txBufState[5:0], txFetchState, txCloseState, 3'b000, txFifoState}; // R10
         snapZero <= {6'h00, txMacState, 2'b00, txDeferState, mgmtIfState}; // R11
         snapOne <= {1'b0, arbiterState, pauseTxState, 10'h000, busMasterState, 8'h00}; // R12
      end
   end

   // ***********************************
   // debug configuration
   // ***********************************

   // only the documented fields are stored, the rest read zero
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         groupSel <= RST_GROUP_SEL;
         debugFlags <= 2'b00;
         funcEnable <= 2'b00;
      end else if (clkEn && cfgWr) begin
         groupSel <= regWrData[GROUP_SEL_LSB +: 6]; // R14
         debugFlags <= regWrData[FLAG_LSB +: 2]; // R15
         funcEnable <= regWrData[FUNC_EN_LSB +: 2]; // R16
      end
   end

   // observation mux, registered so the pins never glitch
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         debugObserve <= 16'h0000;
      end else if (clkEn) begin
         case (groupSel)
            GROUP_TX_DMA: begin
               debugObserve <= {debugFlags[0], txBufState, txDmaState}; // R17
            end
            GROUP_RX_DMA: begin
               debugObserve <= {debugFlags[0], rxBufState, rxDmaState};
            end
            // groups whose signals live elsewhere show zero
            default: begin
               debugObserve <= 16'h0000;
            end
         endcase
      end
   end

   // ***********************************
   // register read
   // ***********************************

   // read mux; unmapped and write-only addresses read zero
   always_comb begin
      next_regRdData = 32'h00000000;
      case (regAddr)
         ADDR_PAUSE_CNT: begin
            next_regRdData = {16'h0000, pauseCount}; // R01
         end
         ADDR_LEN_CAP: begin
            next_regRdData = {16'h0000, lenTypeField}; // R18
         end
         ADDR_TX_DESC: begin
            next_regRdData = txDescAddr; // R05
         end
         ADDR_TX_BUF: begin
            next_regRdData = txBufAddr; // R06
         end
         ADDR_RX_DESC: begin
            next_regRdData = rxDescAddr; // R07
         end
         ADDR_RX_BUF: begin
            next_regRdData = rxBufAddr; // R08
         end
         ADDR_RX_SNAP: begin
            next_regRdData = rxSnap; // R13
         end
         ADDR_TX_SNAP: begin
            next_regRdData = txSnap;
         end
         ADDR_SNAP0: begin
            next_regRdData = snapZero;
         end
         ADDR_SNAP1: begin
            next_regRdData = snapOne;
         end
         ADDR_DBG_CFG: begin
            next_regRdData = {8'h00, funcEnable, 14'h0000, debugFlags, groupSel}; // R18
         end
         ADDR_IRQ_STAT: begin
            next_regRdData = {30'h00000000, irqStatus};
         end
         ADDR_IRQ_EN: begin
            next_regRdData = {30'h00000000, irqEnable};
         end
         default: begin
            next_regRdData = 32'h00000000;
         end
      endcase
   end

   // data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         regRdData <= 32'h00000000;
      end else if (clkEn) begin
         if (regRdStrobe) begin
            regRdData <= next_regRdData;
         end else begin
            regRdData <= 32'h00000000;
         end
      end
   end

   // ***********************************
   // assertions
   // ***********************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   chk_pause_load: assert property ( // R01
      clkEn && pauseTxDone |=> pauseCount == $past(pauseOperand))
      else $error("pause count not loaded from operand");

   chk_pause_step: assert property ( // R01
      clkEn && !pauseTxDone && pauseSlotTick && (pauseCount != 16'h0000)
      |=> pauseCount == $past(pauseCount) - 16'h0001)
      else $error("pause count did not step down by one");

   chk_len_capture: assert property ( // R02
      clkEn && lenTypeValid |=> lenTypeField == $past(lenTypeValue))
      else $error("length/type not captured");

   chk_len_w1c: assert property ( // R03
      clkEn && lenWr && !lenTypeValid
      |=> lenTypeField == ($past(lenTypeField) & ~$past(regWrData[15:0])))
      else $error("write-one-to-clear wrong");

   chk_len_irq: assert property ( // R04
      clkEn && lenTypeValid && irqEnable[IRQ_LEN_BIT] && !regWrStrobe
      |=> irqStatus[IRQ_LEN_BIT] && irq)
      else $error("length event did not raise interrupt");

   chk_desc_read: assert property ( // R05
      clkEn && regRdStrobe && (regAddr == ADDR_TX_DESC)
      |=> regRdData == $past(txDescAddr))
      else $error("tx descriptor address read wrong");

   chk_snap_reserved: assert property ( // R18
      clkEn && regRdStrobe && (regAddr == ADDR_TX_SNAP)
      |=> (regRdData[23:22] == 2'b00) && (regRdData[7:5] == 3'b000))
      else $error("tx snapshot reserved bits not zero");

   chk_cfg_write: assert property ( // R14
      clkEn && cfgWr |=> (groupSel == $past(regWrData[5:0]))
      && (debugFlags == $past(regWrData[7:6])) && (funcEnable == $past(regWrData[23:22])))
      else $error("debug config write not applied");

   chk_group_one: assert property ( // R17
      clkEn && (groupSel == GROUP_TX_DMA) && !cfgWr
      |=> debugObserve == {$past(debugFlags[0]), $past(txBufState), $past(txDmaState)})
      else $error("group one observe wrong");

   // the last tick of a pause must leave zero and a pending flag
   chk_pause_expire: assert property ( // R01
      clkEn && pauseExpire |=> irqStatus[IRQ_PAUSE_BIT] && (pauseCount == 16'h0000))
      else $error("pause expiry not flagged");

   // a clear landing with a new event must not lose the event
   chk_set_wins: assert property ( // R04
      clkEn && clrWr && regWrData[IRQ_LEN_BIT] && lenTypeValid && irqEnable[IRQ_LEN_BIT]
      |=> irqStatus[IRQ_LEN_BIT])
      else $error("length event lost to a clear");

   // read data stands one cycle only, zero otherwise
   chk_rd_idle: assert property ( // R18
      clkEn && !regRdStrobe |=> regRdData == 32'h00000000)
      else $error("read data not zero outside a read");

   // group select only moves on a config write
   chk_cfg_hold: assert property ( // R14
      clkEn && !cfgWr |=> groupSel == $past(groupSel))
      else $error("group select changed without a write");

endmodule : mac_dma_status_debug_regs
`default_nettype wire

// file: mac_dma_status_debug_regs_tb.sv
// self-checking bench for the mac dma status and debug register bank
`timescale 1ns/100ps
`default_nettype none
module mac_dma_status_debug_regs_tb;
   import mac_dbg_pkg::*;
   // ***********************************
   // signals
   // ***********************************
   typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] e;} row_s; // table row
   logic sys_clk, rst, clkEn;
   logic [31:0] regAddr, regWrData, regRdData, rdVal, cfg;
   logic regWrStrobe, regRdStrobe, pauseTxDone, pauseSlotTick, lenTypeValid, irq;
   logic [15:0] pauseOperand, lenTypeValue, debugObserve;
   logic [31:0] txDescAddr, txBufAddr, rxDescAddr, rxBufAddr;
   logic [8:0] rxDmaState;
   logic [5:0] rxBufState, txDeferState, busMasterState;
   logic [3:0] rxFetchState, rxCloseState, txFetchState, txCloseState, pauseTxState;
   logic [7:0] rxFifoState, txDmaState, mgmtIfState;
   logic [6:0] txBufState;
   logic [4:0] txFifoState;
   logic [9:0] txMacState;
   logic [2:0] arbiterState;
   logic [1:0] debugFlags, funcEnable;
   logic [15:0] obs; // expected observe group
   int nErrors = 0; // mismatches seen
   int comparisons = 0; // checks made
   row_s rows [12]; // ordinary write-then-read cases
   logic [31:0] rstA [8]; // addresses checked right after reset
   logic [31:0] rstV [8]; // and what they hold there
   // ***********************************
   // design under test
   // ***********************************
   mac_dma_status_debug_regs uut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
      .pauseTxDone(pauseTxDone), .pauseOperand(pauseOperand), .pauseSlotTick(pauseSlotTick),
      .lenTypeValid(lenTypeValid), .lenTypeValue(lenTypeValue), .txDescAddr(txDescAddr),
      .txBufAddr(txBufAddr), .rxDescAddr(rxDescAddr), .rxBufAddr(rxBufAddr), .rxDmaState(rxDmaState),
      .rxBufState(rxBufState), .rxFetchState(rxFetchState), .rxCloseState(rxCloseState),
      .rxFifoState(rxFifoState), .txDmaState(txDmaState), .txBufState(txBufState),
      .txFetchState(txFetchState), .txCloseState(txCloseState), .txFifoState(txFifoState),
      .txMacState(txMacState), .txDeferState(txDeferState), .mgmtIfState(mgmtIfState),
      .arbiterState(arbiterState), .pauseTxState(pauseTxState), .busMasterState(busMasterState),
      .debugObserve(debugObserve), .debugFlags(debugFlags), .funcEnable(funcEnable), .irq(irq));
   // ***********************************
   // clock and watchdog
   // ***********************************
   // 10 MHz system clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // the whole run is under two hundred cycles, so 5000 is ample
   initial begin
      #500000;
      nErrors++;
      finish_test();
   end
   // ***********************************
   // tasks
   // ***********************************
   // compare and count; case inequality so an unknown never matches
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   // one-cycle write strobe
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge sys_clk);
      regWrStrobe <= 1'b0;
   endtask : wr
   // one-cycle read strobe; data stands only in the following cycle
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge sys_clk);
      regRdStrobe <= 1'b0;
      #1 d = regRdData;
   endtask : rd
   // one-cycle pulse on an event input: 0 pause done, 1 slot tick, 2 length valid
   task automatic ev(input int which);
      @(posedge sys_clk);
      pauseTxDone <= (which == 0);
      pauseSlotTick <= (which == 1);
      lenTypeValid <= (which == 2);
      @(posedge sys_clk);
      pauseTxDone <= 1'b0;
      pauseSlotTick <= 1'b0;
      lenTypeValid <= 1'b0;
   endtask : ev
   // counts, verdict, end of run
   task automatic finish_test();
      $display("errors %0d comparisons %0d", nErrors, comparisons);
      if (nErrors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      // every input has a value at time zero
      rst = 1'b1; clkEn = 1'b1; regAddr = '0; regWrData = '0; regWrStrobe = 1'b0; regRdStrobe = 1'b0;
      pauseTxDone = 1'b0; pauseOperand = 16'h0003; pauseSlotTick = 1'b0;
      lenTypeValid = 1'b0; lenTypeValue = 16'h86DD;
      txDescAddr = 32'h1234_5678; txBufAddr = 32'h9ABC_DEF0; rxDescAddr = 32'h0F1E_2D3C; rxBufAddr = 32'hC3D2_E1F0;
      rxDmaState = 9'h1A5; rxBufState = 6'h2B; rxFetchState = 4'h9; rxCloseState = 4'h6; rxFifoState = 8'hC3;
      txDmaState = 8'hA7; txBufState = 7'h5A; txFetchState = 4'h3; txCloseState = 4'hE; txFifoState = 5'h15;
      txMacState = 10'h2C9; txDeferState = 6'h35; mgmtIfState = 8'h6E;
      arbiterState = 3'h5; pauseTxState = 4'hB; busMasterState = 6'h27;
      rstA = '{ADDR_RX_SNAP, ADDR_TX_SNAP, ADDR_SNAP0, ADDR_SNAP1, ADDR_DBG_CFG, ADDR_LEN_CAP, ADDR_PAUSE_CNT,
         ADDR_IRQ_STAT};
      rstV = '{RST_RX_SNAP, RST_TX_SNAP, RST_SNAP0, RST_SNAP1, 32'h0000_003F, 32'h0, 32'h0, 32'h0};
      // snapshot layouts; upper tx buffer bit is not in the snapshot
      rows[0] = '{ADDR_RX_SNAP, 32'hFFFF_FFFF,
         {rxDmaState, 1'b0, rxBufState, rxFetchState, rxCloseState, rxFifoState}};
      rows[1] = '{ADDR_TX_SNAP, 32'hFFFF_FFFF,
         {txDmaState, 2'b00, txBufState[5:0], txFetchState, txCloseState, 3'b000, txFifoState}};
      rows[2] = '{ADDR_SNAP0, 32'hFFFF_FFFF, {6'h00, txMacState, 2'b00, txDeferState, mgmtIfState}};
      rows[3] = '{ADDR_SNAP1, 32'hFFFF_FFFF, {1'b0, arbiterState, pauseTxState, 10'h000, busMasterState, 8'h00}};
      rows[4] = '{ADDR_TX_DESC, 32'h0, txDescAddr};
      rows[5] = '{ADDR_TX_BUF, 32'h0, txBufAddr};
      rows[6] = '{ADDR_RX_DESC, 32'hFFFF_FFFF, rxDescAddr};
      rows[7] = '{ADDR_RX_BUF, 32'h0, rxBufAddr};
      rows[8] = '{ADDR_PAUSE_CNT, 32'hFFFF_FFFF, 32'h0};
      rows[9] = '{32'hFFF0_30E0, 32'hFFFF_FFFF, 32'h0}; // unmapped hole
      rows[10] = '{ADDR_DBG_CFG, 32'hFFFF_FFFF, 32'h00C0_00FF};
      rows[11] = '{ADDR_IRQ_EN, 32'hFFFF_FFFF, 32'h0000_0003};
      // reset values: each read lands on the first edge after a fresh reset,
      // before the snapshots pick up the live state
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         rst <= 1'b1;
         repeat (4) @(posedge sys_clk);
         rst <= 1'b0;
         regAddr <= rstA[i];
         regRdStrobe <= 1'b1;
         @(posedge sys_clk);
         regRdStrobe <= 1'b0;
         #1 check(regRdData, rstV[i], "reset value");
         check({27'h0, debugFlags, funcEnable, irq}, 32'h0, "outputs after reset");
      end
      // ordinary cases: write, then read back
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, rdVal);
         check(rdVal, rows[i].e, "table row");
      end
      // debug group one and the config-driven outputs
      // each flag and enable bit alone, then the rx group and an empty group
      for (int i = 0; i < 4; i++) begin
         cfg = (i == 0) ? 32'h0040_0041 : (i == 1) ? 32'h0080_0081 : (i == 2) ? 32'h0000_0002 : 32'h0000_003F;
         obs = (i < 2) ? {cfg[6], txBufState, txDmaState} : (i == 2) ? {cfg[6], rxBufState, rxDmaState} : 16'h0000;
         wr(ADDR_DBG_CFG, cfg);
         repeat (2) @(posedge sys_clk);
         #1 check({16'h0, debugObserve}, {16'h0, obs}, "observe group");
         check({30'h0, debugFlags}, {30'h0, cfg[7:6]}, "flags");
         check({30'h0, funcEnable}, {30'h0, cfg[23:22]}, "function enables");
      end
      // remote pause countdown, with a frozen tick in the middle
      wr(ADDR_IRQ_EN, 32'h2);
      ev(0);
      rd(ADDR_PAUSE_CNT, rdVal);
      check(rdVal, 32'h3, "pause load");
      ev(1);
      @(posedge sys_clk);
      clkEn <= 1'b0;
      pauseSlotTick <= 1'b1;
      @(posedge sys_clk);
      clkEn <= 1'b1;
      pauseSlotTick <= 1'b0;
      rd(ADDR_PAUSE_CNT, rdVal);
      check(rdVal, 32'h2, "pause count");
      ev(1);
      ev(1);
      ev(1); // already zero: must not wrap
      rd(ADDR_PAUSE_CNT, rdVal);
      check(rdVal, 32'h0, "pause expired");
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal, 32'h2, "pause flag");
      check({31'h0, irq}, 32'h1, "pause irq");
      wr(ADDR_IRQ_CLR, 32'h2);
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal, 32'h0, "pause flag cleared");
      check({31'h0, irq}, 32'h0, "pause irq cleared");
      // length/type capture while its interrupt is disabled
      wr(ADDR_IRQ_EN, 32'h0);
      ev(2);
      rd(ADDR_LEN_CAP, rdVal);
      check(rdVal, 32'h0000_86DD, "length capture");
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal, 32'h0, "no flag while disabled");
      wr(ADDR_LEN_CAP, 32'hFFFF_0005);
      rd(ADDR_LEN_CAP, rdVal);
      check(rdVal, 32'h0000_86D8, "ones clear");
      wr(ADDR_LEN_CAP, 32'h0);
      rd(ADDR_LEN_CAP, rdVal);
      check(rdVal, 32'h0000_86D8, "zeros leave");
      // enabled length event raises, masks and clears
      wr(ADDR_IRQ_EN, 32'h1);
      @(posedge sys_clk);
      lenTypeValue <= 16'h0600;
      ev(2);
      rd(ADDR_LEN_CAP, rdVal);
      check(rdVal, 32'h0000_0600, "second capture");
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal, 32'h1, "length flag");
      check({31'h0, irq}, 32'h1, "length irq");
      wr(ADDR_IRQ_EN, 32'h0);
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal, 32'h1, "masked flag");
      check({31'h0, irq}, 32'h0, "masked irq");
      wr(ADDR_IRQ_CLR, 32'h1);
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal, 32'h0, "flag cleared");
      // a clear and a new event in one cycle: the event wins
      wr(ADDR_IRQ_EN, 32'h1);
      @(posedge sys_clk);
      regAddr <= ADDR_IRQ_CLR;
      regWrData <= 32'h1;
      regWrStrobe <= 1'b1;
      lenTypeValid <= 1'b1;
      @(posedge sys_clk);
      regWrStrobe <= 1'b0;
      lenTypeValid <= 1'b0;
      rd(ADDR_IRQ_STAT, rdVal);
      check(rdVal, 32'h1, "set beats clear");
      finish_test();
   end
endmodule : mac_dma_status_debug_regs_tb
`default_nettype wire
